// ---- logic/fpcc_pkg.sv ----
// Package of constants and carrier types for the front panel console control
package fpcc_pkg;

   // ==========================================================
   // Widths
   localparam int FPCC_SW_W      = 16;
   localparam int FPCC_BYTE_W    = 8;
   localparam int FPCC_ADDR_W    = 14;

   // ==========================================================
   // Field positions within the panel switch word
   localparam int FPCC_PORT_LSB  = 9;
   localparam int FPCC_PORT_MSB  = 13;
   localparam int FPCC_HIGH_LSB  = 8;

   // ==========================================================
   // Timing
   localparam int FPCC_CLK_HZ       = 20_000_000;
   localparam int FPCC_STEP_NS      = 4000;
   localparam int FPCC_STEP_CYCLES  = (FPCC_STEP_NS * (FPCC_CLK_HZ / 1_000_000)) / 1000;
   localparam int FPCC_DEBOUNCE_NS  = 1000;
   localparam int FPCC_DEBOUNCE_CYC = (FPCC_DEBOUNCE_NS * (FPCC_CLK_HZ / 1_000_000)) / 1000;

   // ==========================================================
   // Reset values and fixed codes
   localparam logic [7:0]  FPCC_RESTART_ZERO = 8'h05;
   localparam logic [7:0]  FPCC_PASS_RST     = 8'h00;
   localparam logic [15:0] FPCC_ADDR_RST     = 16'h0000;

   // ==========================================================
   // Panel switch indices
   localparam int FPCC_NSW       = 11;
   localparam int FPCC_SW_WAIT   = 0;
   localparam int FPCC_SW_STEP   = 1;
   localparam int FPCC_SW_PORT   = 2;
   localparam int FPCC_SW_STORE  = 3;
   localparam int FPCC_SW_INT    = 4;
   localparam int FPCC_SW_RST    = 5;
   localparam int FPCC_SW_SENSE  = 6;
   localparam int FPCC_SW_PASS   = 7;
   localparam int FPCC_SW_LOAD   = 8;
   localparam int FPCC_SW_INC    = 9;
   localparam int FPCC_SW_DEC    = 10;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic yield_req;
      logic int_req;
      logic reset_req;
      logic pause_req;
   } fpcc_req_type;

   typedef struct packed {
      logic       port_write;
      logic [7:0] data_out;
   } fpcc_wr_type;

   typedef enum logic [2:0] {
      FPCC_RUN   = 3'b001,
      FPCC_PAUSE = 3'b010,
      FPCC_STEP  = 3'b100
   } fpcc_pause_type;

endpackage

// ---- logic/fpcc_debounce.sv ----
// Debouncer and single press detector for a bank of panel switches
`timescale 1ns/10ps
`default_nettype none
module fpcc_debounce
   import fpcc_pkg::*;
#(
   parameter int N      = FPCC_NSW,
   parameter int CYCLES = FPCC_DEBOUNCE_CYC
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic [N-1:0] raw_i,
   output logic      [N-1:0] level_o,
   output logic      [N-1:0] press_o
);

   localparam int CW = $clog2(CYCLES + 1);

   initial begin
      if (N < 1 || CYCLES < 1) begin
         $error("fpcc_debounce: bad parameters");
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_sw
         logic          stable_reg;
         logic [CW-1:0] cnt_reg;

         // A level must hold for the full count before it is believed
         always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               stable_reg <= 1'b0;
               cnt_reg    <= '0;
            end else if (raw_i[g] == stable_reg) begin
               cnt_reg <= '0;
            end else if (cnt_reg == CW'(CYCLES - 1)) begin
               stable_reg <= raw_i[g];
               cnt_reg    <= '0;
            end else begin
               cnt_reg <= cnt_reg + CW'(1);
            end
         end

         always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               level_o[g] <= 1'b0;
               press_o[g] <= 1'b0;
            end else begin
               level_o[g] <= stable_reg;
               press_o[g] <= stable_reg & ~level_o[g];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ---- logic/fpcc_console.sv ----
// Front panel console control: switch actions to processor requests and bus activity
// Behaviour
// - Port switch raises the yield request.
// - Switches 9..13 drive the address bus in port access.
// - Port read routes data-in to data-out.
// - Port store sends the low switch byte with one write pulse.
// - Interrupt switch sets a request flop held until interrupt cycle.
// - Interrupt flop drives the interrupt request.
// - Pending interrupt gates low switch byte to instruction bus.
// - Interrupt cycle clears the interrupt flop.
// - Restart switch raises the reset request like an interrupt.
// - Restart places a fixed restart-to-zero instruction.
// - Sense switch drives the high switch byte to the input bus.
// - With sense on, processor inputs take switch data.
// - Pass-load switch loads the low byte into the pass counter.
// - Load switch copies switches to the search address.
// - Each address match decrements the pass counter by one while it is nonzero; at zero it holds.
// - Pass counter reaching zero sets search complete.
// - Search complete raises the pause request.
// - Wait switch enters pause mode, raising the pause request.
// - In wait, single-cycle switch drops pause for about 4 us.
// - Address register: sixteen-bit up/down counter loaded from switches.
// - Store request qualified by sync and mode writes once, then clears.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module fpcc_console
   import fpcc_pkg::*;
#(
   parameter int STEP_CYCLES = FPCC_STEP_CYCLES,
   parameter int DEB_CYCLES  = FPCC_DEBOUNCE_CYC
) (
   input  wire logic                   clk_i,
   input  wire logic                   rstn_i,
   input  wire logic [FPCC_NSW-1:0]    panel_sw_i,
   input  wire logic [FPCC_SW_W-1:0]   data_sw_i,
   input  wire logic                   yield_grant_i,
   input  wire logic                   wait_ack_i,
   input  wire logic                   int_cycle_i,
   input  wire logic                   processor_sync_phase_i,
   input  wire logic                   input_cycle_i,
   input  wire logic [FPCC_ADDR_W-1:0] mem_addr_i,
   input  wire logic [FPCC_BYTE_W-1:0] data_in_i,
   input  wire logic [FPCC_BYTE_W-1:0] src_input_i,
   output logic                        yield_req_o,
   output logic                        int_req_o,
   output logic                        reset_req_o,
   output logic                        pause_req_o,
   output logic [FPCC_ADDR_W-1:0]      mem_addr_o,
   output logic                        mem_addr_oe_o,
   output logic [FPCC_BYTE_W-1:0]      data_out_o,
   output logic                        data_out_oe_o,
   output logic                        port_write_o,
   output logic [FPCC_BYTE_W-1:0]      int_instr_o,
   output logic [FPCC_BYTE_W-1:0]      input_bus_o,
   output logic                        input_override_enable_o,
   output logic [FPCC_SW_W-1:0]        addr_reg_o,
   output logic [FPCC_BYTE_W-1:0]      pass_count_o,
   output logic                        search_complete_o,
   output logic                        port_mode_o,
   output logic                        wait_mode_o
);

   localparam int SCW = $clog2(STEP_CYCLES + 1);

   initial begin
      if (STEP_CYCLES < 1 || DEB_CYCLES < 1) begin
         $error("fpcc_console: cycle counts must be at least one");
      end
   end

   // ==========================================================
   // Switch conditioning
   logic [FPCC_NSW-1:0] sw_level;
   logic [FPCC_NSW-1:0] sw_press;

   fpcc_debounce #(
      .N      (FPCC_NSW),
      .CYCLES (DEB_CYCLES)
   ) u_debounce (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .raw_i   (panel_sw_i),
      .level_o (sw_level),
      .press_o (sw_press)
   );

   function automatic logic pressed(input logic [FPCC_NSW-1:0] p, input int idx);
      return p[idx];
   endfunction

   logic store_switch;
   logic interrupt_switch_pulse;
   logic restart_switch_pulse;
   assign store_switch           = pressed(sw_press, FPCC_SW_STORE);
   assign interrupt_switch_pulse = pressed(sw_press, FPCC_SW_INT);
   assign restart_switch_pulse   = pressed(sw_press, FPCC_SW_RST);

   // ==========================================================
   // Mode flops: port access toggles, sense toggles
   logic port_mode_reg;
   logic sense_mode_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         port_mode_reg <= 1'b0;
      end else if (pressed(sw_press, FPCC_SW_PORT)) begin
         port_mode_reg <= ~port_mode_reg;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sense_mode_reg <= 1'b0;
      end else if (pressed(sw_press, FPCC_SW_SENSE)) begin
         sense_mode_reg <= ~sense_mode_reg;
      end
   end

   // ==========================================================
   // Interrupt and restart request flops
   logic int_flag_reg;
   logic rst_flag_reg;

   // Set wins over a clearing interrupt cycle
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         int_flag_reg <= 1'b0;
      end else if (interrupt_switch_pulse) begin
         int_flag_reg <= 1'b1;
      end else if (int_cycle_i) begin
         int_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_flag_reg <= 1'b0;
      end else if (restart_switch_pulse) begin
         rst_flag_reg <= 1'b1;
      end else if (int_cycle_i) begin
         rst_flag_reg <= 1'b0;
      end
   end

   logic interrupt_vector_gate;
   logic restart_vector_gate;
   assign restart_vector_gate   = rst_flag_reg;
   assign interrupt_vector_gate = int_flag_reg & ~rst_flag_reg;

   // ==========================================================
   // Store flop: one write pulse per press
   logic store_request;
   logic write_strobe;
   assign write_strobe = store_request & processor_sync_phase_i & port_mode_reg & yield_grant_i;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         store_request <= 1'b0;
      end else if (store_switch) begin
         store_request <= 1'b1;
      end else if (write_strobe) begin
         store_request <= 1'b0;
      end
   end

   // ==========================================================
   // Search address register and pass counter
   logic [FPCC_SW_W-1:0]   addr_reg;
   logic [FPCC_BYTE_W-1:0] pass_reg;
   logic                   search_done_reg;
   logic                   match_prev_reg;
   logic                   address_match;
   logic                   pass_count_strobe;
   logic                   pass_exhausted;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         addr_reg <= FPCC_ADDR_RST;
      end else if (pressed(sw_press, FPCC_SW_LOAD)) begin
         addr_reg <= data_sw_i;
      end else if (pressed(sw_press, FPCC_SW_INC)) begin
         addr_reg <= addr_reg + 16'h0001;
      end else if (pressed(sw_press, FPCC_SW_DEC)) begin
         addr_reg <= addr_reg - 16'h0001;
      end
   end

   // Only the bus width of the address is compared
   assign address_match = (addr_reg[FPCC_ADDR_W-1:0] == mem_addr_i) & ~yield_grant_i;

   // One decrement per coincidence, not per clock it lasts
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         match_prev_reg <= 1'b0;
      end else begin
         match_prev_reg <= address_match;
      end
   end

   assign pass_count_strobe = address_match & ~match_prev_reg;
   assign pass_exhausted    = (pass_reg == 8'h01) & pass_count_strobe;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pass_reg <= FPCC_PASS_RST;
      end else if (pressed(sw_press, FPCC_SW_PASS)) begin
         pass_reg <= data_sw_i[FPCC_BYTE_W-1:0];
      end else if (pass_count_strobe && pass_reg != 8'h00) begin
         pass_reg <= pass_reg - 8'h01;
      end
   end

   // Only a fresh pass load clears it
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         search_done_reg <= 1'b0;
      end else if (pass_exhausted) begin
         search_done_reg <= 1'b1;
      end else if (pressed(sw_press, FPCC_SW_PASS)) begin
         search_done_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Pause control: wait mode and single cycle release
   fpcc_pause_type     pause_state_reg;
   logic [SCW-1:0]     step_cnt_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pause_state_reg <= FPCC_RUN;
      end else begin
         unique case (pause_state_reg)
            FPCC_RUN: begin
               if (pressed(sw_press, FPCC_SW_WAIT)) begin
                  pause_state_reg <= FPCC_PAUSE;
               end
            end
            FPCC_PAUSE: begin
               if (pressed(sw_press, FPCC_SW_WAIT)) begin
                  pause_state_reg <= FPCC_RUN;
               end else if (pressed(sw_press, FPCC_SW_STEP) && wait_ack_i) begin
                  pause_state_reg <= FPCC_STEP;
               end
            end
            FPCC_STEP: begin
               if (step_cnt_reg == SCW'(STEP_CYCLES - 1)) begin
                  pause_state_reg <= FPCC_PAUSE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         step_cnt_reg <= '0;
      end else if (pause_state_reg == FPCC_STEP) begin
         step_cnt_reg <= step_cnt_reg + SCW'(1);
      end else begin
         step_cnt_reg <= '0;
      end
   end

   // ==========================================================
   // Request multiplexer
   fpcc_req_type req_next;
   always_comb begin
      req_next.yield_req = port_mode_reg;
      req_next.int_req   = int_flag_reg;
      req_next.reset_req = rst_flag_reg;
      // Search completion holds pause even through a step release
      req_next.pause_req = (pause_state_reg == FPCC_PAUSE) | search_done_reg;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         yield_req_o <= 1'b0;
         int_req_o   <= 1'b0;
         reset_req_o <= 1'b0;
         pause_req_o <= 1'b0;
      end else begin
         yield_req_o <= req_next.yield_req;
         int_req_o   <= req_next.int_req;
         reset_req_o <= req_next.reset_req;
         pause_req_o <= req_next.pause_req;
      end
   end

   // ==========================================================
   // Bus drivers; address and data enables wait for the grant so no two parties drive at once
   fpcc_wr_type wr_next;
   always_comb begin
      wr_next.port_write = write_strobe;
      if (store_request) begin
         wr_next.data_out = data_sw_i[FPCC_BYTE_W-1:0];
      end else begin
         wr_next.data_out = data_in_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem_addr_o    <= '0;
         mem_addr_oe_o <= 1'b0;
         data_out_o    <= 8'h00;
         data_out_oe_o <= 1'b0;
         port_write_o  <= 1'b0;
      end else begin
         mem_addr_o    <= {{(FPCC_ADDR_W-5){1'b0}}, data_sw_i[FPCC_PORT_MSB:FPCC_PORT_LSB]};
         mem_addr_oe_o <= port_mode_reg & yield_grant_i;
         data_out_o    <= wr_next.data_out;
         data_out_oe_o <= port_mode_reg & yield_grant_i;
         port_write_o  <= wr_next.port_write;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         int_instr_o <= 8'h00;
      end else if (restart_vector_gate) begin
         int_instr_o <= FPCC_RESTART_ZERO;
      end else if (interrupt_vector_gate) begin
         int_instr_o <= data_sw_i[FPCC_BYTE_W-1:0];
      end else begin
         int_instr_o <= 8'h00;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         input_bus_o             <= 8'h00;
         input_override_enable_o <= 1'b0;
      end else begin
         input_override_enable_o <= sense_mode_reg & input_cycle_i;
         if (sense_mode_reg) begin
            input_bus_o <= data_sw_i[FPCC_SW_W-1:FPCC_HIGH_LSB];
         end else begin
            input_bus_o <= src_input_i;
         end
      end
   end

   // ==========================================================
   // Status for the lamps
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         addr_reg_o        <= FPCC_ADDR_RST;
         pass_count_o      <= FPCC_PASS_RST;
         search_complete_o <= 1'b0;
         port_mode_o       <= 1'b0;
         wait_mode_o       <= 1'b0;
      end else begin
         addr_reg_o        <= addr_reg;
         pass_count_o      <= pass_reg;
         search_complete_o <= search_done_reg;
         port_mode_o       <= port_mode_reg;
         wait_mode_o       <= (pause_state_reg != FPCC_RUN);
      end
   end

endmodule
`default_nettype wire

// ---- verif/fpcc_console_props.sv ----
// Checker of console request, bus and pulse relations
`timescale 1ns/10ps
`default_nettype none
module fpcc_console_props
   import fpcc_pkg::*;
(
   input wire logic                   clk_i,
   input wire logic                   rstn_i,
   input wire logic [FPCC_SW_W-1:0]   data_sw_i,
   input wire logic                   int_cycle_i,
   input wire logic                   input_cycle_i,
   input wire logic                   yield_req_o,
   input wire logic                   int_req_o,
   input wire logic                   reset_req_o,
   input wire logic                   pause_req_o,
   input wire logic [FPCC_ADDR_W-1:0] mem_addr_o,
   input wire logic                   mem_addr_oe_o,
   input wire logic                   data_out_oe_o,
   input wire logic                   port_write_o,
   input wire logic [FPCC_BYTE_W-1:0] int_instr_o,
   input wire logic                   input_override_enable_o,
   input wire logic [FPCC_BYTE_W-1:0] pass_count_o,
   input wire logic                   search_complete_o,
   input wire logic                   port_mode_o,
   input wire logic                   wait_mode_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ==========================================================
   // Requests toward the processor
   int_hold_a: assert property (int_req_o && !$past(int_cycle_i) |=> int_req_o)
      else $error("interrupt dropped early");
   int_vector_a: assert property (int_req_o && !reset_req_o |-> int_instr_o == $past(data_sw_i[7:0]))
      else $error("wrong interrupt byte");
   restart_code_a: assert property (reset_req_o |-> int_instr_o == FPCC_RESTART_ZERO)
      else $error("wrong restart code");
   yield_mode_a: assert property (port_mode_o && $past(port_mode_o) |-> yield_req_o)
      else $error("no yield request");
   search_pause_a: assert property ($rose(search_complete_o) |-> ##[0:2] pause_req_o)
      else $error("no search pause");
   wait_pause_a: assert property ($rose(wait_mode_o) |-> ##[0:2] pause_req_o)
      else $error("no wait pause");
   // ==========================================================
   // Bus side
   port_addr_a: assert property (mem_addr_oe_o |->
      mem_addr_o == FPCC_ADDR_W'($past(data_sw_i[FPCC_PORT_MSB:FPCC_PORT_LSB])))
      else $error("wrong port address");
   oe_pair_a: assert property (mem_addr_oe_o == data_out_oe_o)
      else $error("enables differ");
   write_once_a: assert property (port_write_o |=> !port_write_o)
      else $error("long port write");
   write_mode_a: assert property (port_write_o |-> port_mode_o)
      else $error("write outside port mode");
   sense_gate_a: assert property (input_override_enable_o |-> $past(input_cycle_i))
      else $error("stray override");
   pass_done_a: assert property (pass_count_o == 8'h00 && $past(pass_count_o) == 8'h01
      |-> ##[0:2] search_complete_o)
      else $error("no search complete");
   port_write_c: cover property (port_write_o);
   search_c: cover property (search_complete_o && pause_req_o);
   step_c: cover property ($fell(pause_req_o) && wait_mode_o);
endmodule

bind fpcc_console fpcc_console_props u_props (.*);
`default_nettype wire

// ---- verif/fpcc_proc_model.sv ----
// Behavioural model of the processor that faces the console
`timescale 1ns/10ps
`default_nettype none
module fpcc_proc_model
   import fpcc_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rstn_i,
   input  wire logic                   slow_i,
   input  wire logic                   yield_req_i,
   input  wire logic                   int_req_i,
   input  wire logic                   reset_req_i,
   input  wire logic                   pause_req_i,
   input  wire logic [FPCC_ADDR_W-1:0] addr_i,
   input  wire logic [FPCC_ADDR_W-1:0] port_addr_i,
   output logic                        yield_grant_o,
   output logic                        wait_ack_o,
   output logic                        int_cycle_o,
   output logic                        sync_o,
   output logic                        input_cycle_o,
   output logic [FPCC_ADDR_W-1:0]      mem_addr_o,
   output logic [FPCC_BYTE_W-1:0]      data_in_o
);
   logic [3:0]             age_reg;
   logic [2:0]             cyc_reg;
   logic [FPCC_ADDR_W-1:0] last_reg;
   logic                   differ;
   assign differ = (yield_req_i != yield_grant_o) || (pause_req_i != wait_ack_o)
                   || ((int_req_i || reset_req_i) != int_cycle_o);
   assign sync_o = cyc_reg[0];
   assign input_cycle_o = (cyc_reg[2:1] == 2'h3);
   // A released bus holds the inverse of its last driven value
   assign mem_addr_o = yield_grant_o ? ~last_reg : addr_i;
   assign data_in_o = 8'hA0 ^ {3'h0, port_addr_i[4:0]};
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         age_reg <= 4'h0;
         cyc_reg <= 3'h0;
         last_reg <= 14'h0000;
         yield_grant_o <= 1'b0;
         wait_ack_o <= 1'b0;
         int_cycle_o <= 1'b0;
      end else begin
         cyc_reg <= cyc_reg + 3'h1;
         last_reg <= yield_grant_o ? last_reg : addr_i;
         age_reg <= differ ? age_reg + 4'h1 : 4'h0;
         if (age_reg >= (slow_i ? 4'h4 : 4'h1)) begin
            yield_grant_o <= yield_req_i;
            wait_ack_o <= pause_req_i;
            // A waiting processor takes no interrupt
            int_cycle_o <= (int_req_i || reset_req_i) && !wait_ack_o;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/front_panel_console_control_tb.sv ----
// Self-checking bench of the console against a processor model
`timescale 1ns/10ps
`default_nettype none
module front_panel_console_control_tb;
   import fpcc_pkg::*;
   localparam int DEB = 2;
   localparam int STEP = 4;
   logic                   clk_i = 1'b0;
   logic                   rstn_i = 1'b0;
   logic                   slow = 1'b0;
   logic [FPCC_NSW-1:0]    panel_sw_i = 11'h000;
   logic [FPCC_SW_W-1:0]   data_sw_i = 16'h0000;
   logic [FPCC_ADDR_W-1:0] bus_addr = 14'h0000;
   logic [FPCC_BYTE_W-1:0] src_input_i = 8'h3C;
   logic [15:0]            lfsr = 16'h71AC;
   int                     fail_count = 0;
   int                     tests_run = 0;
   wire logic yield_grant_i, wait_ack_i, int_cycle_i, processor_sync_phase_i, input_cycle_i;
   wire logic yield_req_o, int_req_o, reset_req_o, pause_req_o, mem_addr_oe_o, data_out_oe_o;
   wire logic port_write_o, input_override_enable_o, search_complete_o, port_mode_o, wait_mode_o;
   wire logic [FPCC_ADDR_W-1:0] mem_addr_i, mem_addr_o;
   wire logic [FPCC_BYTE_W-1:0] data_in_i, data_out_o, int_instr_o, input_bus_o, pass_count_o;
   wire logic [FPCC_SW_W-1:0]   addr_reg_o;

   fpcc_console #(.STEP_CYCLES(STEP), .DEB_CYCLES(DEB)) uut (.*);
   fpcc_proc_model proc (.clk_i, .rstn_i, .slow_i(slow), .yield_req_i(yield_req_o), .int_req_i(int_req_o),
      .reset_req_i(reset_req_o), .pause_req_i(pause_req_o), .addr_i(bus_addr), .port_addr_i(mem_addr_o),
      .yield_grant_o(yield_grant_i), .wait_ack_o(wait_ack_i), .int_cycle_o(int_cycle_i),
      .sync_o(processor_sync_phase_i), .input_cycle_o(input_cycle_i), .mem_addr_o(mem_addr_i),
      .data_in_o(data_in_i));

   always #25 clk_i = ~clk_i;
   // ==========================================================
   // Shared tasks
   function automatic logic [15:0] next_rand(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want) begin
         fail_count++;
         $display("BAD t=%0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic put(input logic [15:0] v);
      @(posedge clk_i);
      data_sw_i <= v;
   endtask
   // Held past the debounce span
   task automatic press(input int idx);
      @(posedge clk_i);
      panel_sw_i[idx] <= 1'b1;
      repeat (DEB + 4) @(posedge clk_i);
      panel_sw_i[idx] <= 1'b0;
      repeat (DEB + 6) @(posedge clk_i);
   endtask
   task automatic press_count(input int idx, output int n, output logic [7:0] got);
      n = 0;
      got = 8'h00;
      fork
         press(idx);
         repeat (3 * DEB + 12) begin
            @(posedge clk_i);
            #1;
            if (idx == FPCC_SW_STEP ? pause_req_o === 1'b0 : port_write_o === 1'b1) begin
               n++;
               got = data_out_o;
            end
         end
      join
   endtask
   task automatic done(input string s);
      $display("end of %s test", s);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      fail_count++;
      close_out();
   end
   // ==========================================================
   // Main sequence
   initial begin
      int n;
      int k;
      logic [15:0] v;
      logic [7:0] got;
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (DEB + 3) @(posedge clk_i);
      check({yield_req_o, int_req_o, reset_req_o, pause_req_o, pass_count_o}, 16'h0000);
      check(addr_reg_o, FPCC_ADDR_RST);
      press(FPCC_SW_WAIT);
      check(16'({wait_mode_o, pause_req_o}), 16'h0003);
      press_count(FPCC_SW_STEP, n, got);
      check(16'(n), 16'(STEP));
      check(16'(pause_req_o), 16'h0001);
      done("step");
      for (k = 0; k < 2; k++) begin
         lfsr = next_rand(lfsr);
         put(lfsr);
         press(FPCC_SW_INT);
         repeat (4) @(posedge clk_i);
         check(16'({int_req_o, int_instr_o}), {8'h01, data_sw_i[7:0]});
      end
      press(FPCC_SW_RST);
      check(16'({reset_req_o, int_instr_o}), {8'h01, FPCC_RESTART_ZERO});
      press(FPCC_SW_WAIT);
      check(16'({int_req_o, reset_req_o, pause_req_o}), 16'h0000);
      done("interrupt");
      lfsr = next_rand(lfsr);
      put(lfsr);
      press(FPCC_SW_SENSE);
      check(16'(input_bus_o), 16'(data_sw_i[15:8]));
      press(FPCC_SW_SENSE);
      check(16'(input_bus_o), 16'(src_input_i));
      done("sense");
      for (k = 0; k < 3; k++) begin
         lfsr = next_rand(lfsr);
         put(k == 2 ? 16'hFFFF : lfsr);
         press(FPCC_SW_LOAD);
         check(addr_reg_o, data_sw_i);
         press(FPCC_SW_INC);
         check(addr_reg_o, data_sw_i + 16'h0001);
         press(FPCC_SW_DEC);
         press(FPCC_SW_DEC);
         check(addr_reg_o, data_sw_i - 16'h0001);
      end
      done("address");
      v = {2'b00, lfsr[13:0]};
      put(v);
      bus_addr <= v[13:0] ^ 14'h0001;
      press(FPCC_SW_LOAD);
      put(16'h0003);
      press(FPCC_SW_PASS);
      check(16'(pass_count_o), 16'h0003);
      for (k = 2; k >= 0; k--) begin
         @(posedge clk_i);
         bus_addr <= v[13:0];
         @(posedge clk_i);
         bus_addr <= v[13:0] ^ 14'h0001;
         repeat (4) @(posedge clk_i);
         check(16'(pass_count_o), 16'(k));
      end
      check(16'({search_complete_o, pause_req_o}), 16'h0003);
      put(16'h0005);
      press(FPCC_SW_PASS);
      check(16'({search_complete_o, pause_req_o, pass_count_o}), 16'h0005);
      done("search");
      slow <= 1'b1;
      press(FPCC_SW_WAIT);
      lfsr = next_rand(lfsr);
      put(lfsr);
      press(FPCC_SW_PORT);
      repeat (6) @(posedge clk_i);
      check(16'({yield_req_o, mem_addr_oe_o}), 16'h0003);
      check(16'(mem_addr_o), 16'(data_sw_i[13:9]));
      check(16'(data_out_o), 16'(8'hA0 ^ data_sw_i[13:9]));
      press_count(FPCC_SW_STORE, n, got);
      check(16'(n), 16'h0001);
      check(16'(got), 16'(data_sw_i[7:0]));
      press(FPCC_SW_PORT);
      press(FPCC_SW_WAIT);
      check(16'({yield_req_o, pause_req_o}), 16'h0000);
      done("port");
      close_out();
   end
endmodule
`default_nettype wire
